// [hw/atx_pkg.sv]
package atx_pkg;
    localparam logic [7:0]  OP_SET_DIV     = 8'h07;
    localparam logic [7:0]  OP_WR_TXF      = 8'h0E;
    localparam logic [7:0]  OP_CLR_TXF     = 8'h11;
    localparam logic [7:0]  OP_SEND        = 8'h12;
    localparam logic [7:0]  OP_WR_CTRL     = 8'h10;
    localparam logic [7:0]  OP_RD_STAT     = 8'h0A;
    localparam logic [7:0]  OP_RD_CTRL     = 8'h0B;
    localparam int          CR_DIV_SEL     = 1;
    localparam int          CR_PAR_EN      = 3;
    localparam int          CR_LOOP_DIS    = 5;
    localparam int          CR_PAR_EVEN    = 9;
    localparam int          CR_LOW_SPEED   = 10;
    localparam int          CR_NULL_FORCE  = 12;
    localparam int          CR_AUTO_SEND   = 13;
    localparam logic [15:0] CTRL_RST       = 16'h0008;
    localparam logic [7:0]  DIV_RST        = 8'h01;
    localparam int          SR_EMPTY       = 3;
    localparam int          SR_HALF        = 4;
    localparam int          SR_FULL        = 5;
    localparam int          FIFO_DEPTH     = 32;
    localparam int          HALF_LEVEL     = 16;
    localparam int          WORD_BITS      = 32;
    localparam logic [8:0]  HS_HALF_CLK    = 9'h005;
    localparam logic [8:0]  LS_HALF_CLK    = 9'h028;
    localparam logic [8:0]  HS_GAP_CLK     = 9'h028;
    localparam logic [8:0]  LS_GAP_CLK     = 9'h140;
    localparam logic [11:0] HOST_CMD_OFS   = 12'h000;
    localparam logic [11:0] HOST_STAT_OFS  = 12'h004;
    localparam logic [11:0] HOST_CFG_OFS   = 12'h008;
    localparam int          CMD_START_BIT  = 8;
    localparam int          CMD_LAST_BIT   = 9;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_RX_LSB    = 8;
    localparam int          CFG_MRST_BIT   = 0;
    localparam int          SYS_CLK_HZ     = 25000000;
    localparam int          ACLK_HZ        = 1000000;
    localparam int          ACLK_PERIOD    = SYS_CLK_HZ / ACLK_HZ;
    localparam int          ACLK_LOW       = ACLK_PERIOD / 2;
    localparam int          SCK_HALF_CYC   = 2;
endpackage

// [hw/atx_link_if.sv]
`timescale 1ns/100ps
interface atx_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic aclk;
    logic master_reset;
    wire  miso_line;

    // The serial output pin has a pull-down, so an undriven line reads low.
    assign miso_line = miso_oe & miso;

    modport dev (input cs_n, sclk, mosi, aclk, master_reset, output miso, miso_oe);
    modport host (output cs_n, sclk, mosi, aclk, master_reset, input miso_line);
endinterface

// [hw/atx_ref_div.sv]
`timescale 1ns/100ps
module atx_ref_div (
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire logic       aclk_i,
    input  wire logic       div_en_i,
    input  wire logic [7:0] ratio_i,
    output logic            tick_o
);
    logic       aclk_q;
    logic [7:0] edge_cnt;
    wire        aclk_rise = aclk_i & ~aclk_q;
    wire        div_wrap  = (edge_cnt + 8'h01 >= ratio_i);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aclk_q   <= 1'b0;
            edge_cnt <= 8'h00;
            tick_o   <= 1'b0;
        end else begin
            aclk_q <= aclk_i;
            tick_o <= aclk_rise & (~div_en_i | div_wrap);
            if (aclk_rise) begin
                edge_cnt <= (div_en_i & ~div_wrap) ? edge_cnt + 8'h01 : 8'h00;
            end
        end
    end
endmodule // atx_ref_div

// [hw/atx_dev.sv]
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
module atx_dev #(
    parameter int DEPTH = atx_pkg::FIFO_DEPTH
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    atx_link_if.dev   link,
    output logic      line_out_a_o,
    output logic      line_out_b_o,
    output logic      drive_one_out_o,
    output logic      drive_zero_out_o,
    output logic      slow_slope_o,
    output logic      loop_one_o,
    output logic      loop_zero_o,
    output logic      rx_flag_out_o,
    output logic      tx_flag_out_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 * atx_pkg::HALF_LEVEL || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
        $error("atx_dev: DEPTH must be a power of two from 32 to 256");
    end

    typedef enum logic [1:0] {TX_IDLE, TX_MARK, TX_NULL, TX_GAP} atx_tx_state_t;

    logic [31:0]   mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   fill;
    logic [15:0]   ctrl;
    logic [7:0]    ctrl_hi;
    logic [7:0]    div_ratio;
    logic          sclk_q;
    logic          cs_q;
    logic [2:0]    bit_cnt;
    logic [7:0]    in_sr;
    logic          have_cmd;
    logic [7:0]    opcode;
    logic [7:0]    byte_cnt;
    logic [23:0]   word_acc;
    logic          reading;
    logic          first_fall;
    logic [15:0]   out_sr;
    logic          loaded;
    logic          sending;
    atx_tx_state_t tx_state;
    logic [8:0]    phase;
    logic [4:0]    bit_idx;
    logic [31:0]   tx_sr;
    logic          ref_tick;

    // Link edges are found by comparing with last cycle's level.
    wire       sck_rise  = link.sclk & ~sclk_q & ~link.cs_n;
    wire       sck_fall  = ~link.sclk & sclk_q & ~link.cs_n;
    wire       cs_rise   = link.cs_n & ~cs_q;
    wire [7:0] next_byte = {in_sr[6:0], link.mosi};
    wire       byte_done = sck_rise & ~reading & (bit_cnt == 3'h7);
    wire       cmd_done  = byte_done & ~have_cmd;
    wire       dat_done  = byte_done & have_cmd;
    wire       mst_rst   = link.master_reset;

    wire full  = (fill == (AW + 1)'(DEPTH));
    wire half  = (fill >= (AW + 1)'(atx_pkg::HALF_LEVEL));
    wire empty = (fill == '0) & (tx_state == TX_IDLE);

    wire op_clr   = cmd_done & (next_byte == atx_pkg::OP_CLR_TXF);
    wire op_send  = cmd_done & (next_byte == atx_pkg::OP_SEND);
    wire op_rd_st = cmd_done & (next_byte == atx_pkg::OP_RD_STAT);
    wire op_rd_cr = cmd_done & (next_byte == atx_pkg::OP_RD_CTRL);
    wire wr_word  = dat_done & (opcode == atx_pkg::OP_WR_TXF) & (byte_cnt[1:0] == 2'h3);
    wire push     = wr_word & ~full;
    wire wr_ctrl  = dat_done & (opcode == atx_pkg::OP_WR_CTRL);
    wire wr_div   = dat_done & (opcode == atx_pkg::OP_SET_DIV) & (byte_cnt == 8'h00);

    wire par_en    = ctrl[atx_pkg::CR_PAR_EN];
    wire par_even  = ctrl[atx_pkg::CR_PAR_EVEN];
    wire low_speed = ctrl[atx_pkg::CR_LOW_SPEED];
    wire loop_dis  = ctrl[atx_pkg::CR_LOOP_DIS];
    wire null_frc  = ctrl[atx_pkg::CR_NULL_FORCE];
    wire auto_send = ctrl[atx_pkg::CR_AUTO_SEND];

    wire [7:0] status_byte = {2'b00, full, half, empty, 3'b000};

    wire [8:0]  half_len = low_speed ? atx_pkg::LS_HALF_CLK : atx_pkg::HS_HALF_CLK;
    wire [8:0]  gap_len  = low_speed ? atx_pkg::LS_GAP_CLK : atx_pkg::HS_GAP_CLK;
    wire        half_end = (phase == half_len - 9'h001);
    wire        gap_end  = (phase == gap_len - 9'h001);
    wire [31:0] head     = mem[rd_ptr];
    wire        par_bit  = par_even ? ^head[30:0] : ~^head[30:0];
    wire [31:0] head_out = par_en ? {par_bit, head[30:0]} : head;
    wire        can_go   = sending & (fill != '0);
    wire        at_start = (tx_state == TX_IDLE) | ((tx_state == TX_GAP) & gap_end);
    wire        pop      = ref_tick & can_go & at_start & ~mst_rst;

    // Gating with master reset keeps the line quiet in the very next cycle.
    wire next_one  = (tx_state == TX_MARK) & tx_sr[0] & ~null_frc & ~mst_rst;
    wire next_zero = (tx_state == TX_MARK) & ~tx_sr[0] & ~null_frc & ~mst_rst;

    atx_ref_div u_ref_div (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .aclk_i    (link.aclk),
        .div_en_i  (ctrl[atx_pkg::CR_DIV_SEL]),
        .ratio_i   (div_ratio),
        .tick_o    (ref_tick)
    );

    // Serial receive side; a rising chip select throws away any partial byte.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_q   <= 1'b0;
            cs_q     <= 1'b1;
            bit_cnt  <= 3'h0;
            in_sr    <= 8'h00;
            have_cmd <= 1'b0;
            opcode   <= 8'h00;
            byte_cnt <= 8'h00;
            word_acc <= 24'h000000;
        end else begin
            sclk_q <= link.sclk;
            cs_q   <= link.cs_n;
            if (link.cs_n) begin
                bit_cnt  <= 3'h0;
                have_cmd <= 1'b0;
                byte_cnt <= 8'h00;
            end else if (sck_rise & ~reading) begin
                bit_cnt <= bit_cnt + 3'h1;
                in_sr   <= next_byte;
                if (cmd_done) begin
                    have_cmd <= 1'b1;
                    opcode   <= next_byte;
                end
                if (dat_done) begin
                    byte_cnt <= byte_cnt + 8'h01;
                    word_acc <= {word_acc[15:0], next_byte};
                end
            end
        end
    end

    // Read data leaves on falling edges; the first bit is ready before the first rise.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reading      <= 1'b0;
            first_fall   <= 1'b0;
            out_sr       <= 16'h0000;
            link.miso_oe <= 1'b0;
            link.miso    <= 1'b0;
        end else if (link.cs_n) begin
            reading      <= 1'b0;
            link.miso_oe <= 1'b0;
        end else if (op_rd_st | op_rd_cr) begin
            reading      <= 1'b1;
            first_fall   <= 1'b1;
            out_sr       <= op_rd_st ? {status_byte, 8'h00} : ctrl;
            link.miso    <= op_rd_st ? status_byte[7] : ctrl[15];
            link.miso_oe <= 1'b1;
        end else if (sck_fall & reading) begin
            first_fall <= 1'b0;
            if (!first_fall) begin
                out_sr    <= {out_sr[14:0], 1'b0};
                link.miso <= out_sr[14];
            end
        end
    end

    // Master reset leaves the control word alone.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl      <= atx_pkg::CTRL_RST;
            ctrl_hi   <= 8'h00;
            div_ratio <= atx_pkg::DIV_RST;
        end else begin
            if (wr_ctrl & (byte_cnt == 8'h00)) begin
                ctrl_hi <= next_byte;
            end
            if (wr_ctrl & (byte_cnt == 8'h01)) begin
                ctrl <= {ctrl_hi, next_byte};
            end
            if (wr_div) begin
                div_ratio <= next_byte;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= {word_acc, next_byte};
        end
    end

    // Clearing does not wait for a word boundary; a word already in the shifter finishes.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else if (mst_rst | op_clr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            fill   <= fill + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            loaded  <= 1'b0;
            sending <= 1'b0;
        end else if (mst_rst) begin
            loaded  <= 1'b0;
            sending <= 1'b0;
        end else begin
            loaded <= cs_rise ? 1'b0 : (loaded | push);
            if (op_send | (cs_rise & auto_send & loaded)) begin
                sending <= 1'b1;
            end else if ((tx_state == TX_IDLE) & (fill == '0)) begin
                sending <= 1'b0;
            end
        end
    end

    // Bit and gap timing counts reference clock ticks, not system clocks.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_state <= TX_IDLE;
            phase    <= 9'h000;
            bit_idx  <= 5'h00;
            tx_sr    <= 32'h00000000;
        end else if (mst_rst) begin
            tx_state <= TX_IDLE;
            phase    <= 9'h000;
        end else if (pop) begin
            tx_sr    <= head_out;
            tx_state <= TX_MARK;
            phase    <= 9'h000;
            bit_idx  <= 5'h00;
        end else if (ref_tick) begin
            phase <= phase + 9'h001;
            case (tx_state)
                TX_MARK: begin
                    if (half_end) begin
                        tx_state <= TX_NULL;
                        phase    <= 9'h000;
                    end
                end
                TX_NULL: begin
                    if (half_end) begin
                        phase    <= 9'h000;
                        tx_state <= (bit_idx == 5'h1F) ? TX_GAP : TX_MARK;
                        bit_idx  <= bit_idx + 5'h01;
                        tx_sr    <= {1'b0, tx_sr[31:1]};
                    end
                end
                TX_GAP: begin
                    if (gap_end) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    phase <= 9'h000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_out_a_o     <= 1'b0;
            line_out_b_o     <= 1'b0;
            drive_one_out_o  <= 1'b0;
            drive_zero_out_o <= 1'b0;
            slow_slope_o     <= 1'b0;
            loop_one_o       <= 1'b0;
            loop_zero_o      <= 1'b0;
            rx_flag_out_o    <= 1'b0;
            tx_flag_out_o    <= 1'b0;
        end else begin
            line_out_a_o     <= next_one;
            line_out_b_o     <= next_zero;
            drive_one_out_o  <= next_one;
            drive_zero_out_o <= next_zero;
            slow_slope_o     <= low_speed;
            loop_one_o       <= next_one & ~loop_dis;
            loop_zero_o      <= next_zero & ~loop_dis;
            rx_flag_out_o    <= 1'b0;
            tx_flag_out_o    <= half & ~mst_rst;
        end
    end
endmodule // atx_dev

// [hw/atx_host.sv]
`timescale 1ns/100ps
module atx_host #(
    parameter int SCK_HALF = atx_pkg::SCK_HALF_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    atx_link_if.host         link
);
    if (SCK_HALF < 2 || SCK_HALF > 255) begin : g_bad
        $error("atx_host: SCK_HALF must be 2 to 255");
    end

    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} atx_host_state_t;

    atx_host_state_t state;
    logic [7:0]      timer;
    logic [7:0]      tx_byte;
    logic [7:0]      rx_byte;
    logic [2:0]      bits;
    logic            last;
    logic [4:0]      aclk_cnt;

    wire        access  = psel_i & penable_i & ~pready_o;
    wire        wr_done = psel_i & penable_i & pready_o & pwrite_i;
    wire        hit_cmd = (paddr_i == atx_pkg::HOST_CMD_OFS);
    wire        hit_st  = (paddr_i == atx_pkg::HOST_STAT_OFS);
    wire        hit_cfg = (paddr_i == atx_pkg::HOST_CFG_OFS);
    wire        busy    = (state != H_IDLE);
    wire        start   = wr_done & hit_cmd & ~busy & pwdata_i[atx_pkg::CMD_START_BIT];
    wire        tmo     = (timer == 8'(SCK_HALF - 1));
    wire [31:0] st_word = (32'(rx_byte) << atx_pkg::STAT_RX_LSB)
                        | (32'(busy) << atx_pkg::STAT_BUSY_BIT);
    wire [31:0] cf_word = 32'(link.master_reset) << atx_pkg::CFG_MRST_BIT;
    wire [31:0] rd_word = hit_st ? st_word : (hit_cfg ? cf_word : 32'h00000000);

    // One wait state keeps read data registered.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= access;
            prdata_o  <= access ? rd_word : 32'h00000000;
            pslverr_o <= access & ~(hit_cmd | hit_st | hit_cfg);
        end
    end

    // The reference clock is the system clock divided by its odd ratio.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aclk_cnt          <= 5'h00;
            link.aclk         <= 1'b0;
            link.master_reset <= 1'b0;
        end else begin
            aclk_cnt  <= (aclk_cnt == 5'(atx_pkg::ACLK_PERIOD - 1)) ? 5'h00 : aclk_cnt + 5'h01;
            link.aclk <= (aclk_cnt >= 5'(atx_pkg::ACLK_LOW - 1))
                       & (aclk_cnt != 5'(atx_pkg::ACLK_PERIOD - 1));
            if (wr_done & hit_cfg) begin
                link.master_reset <= pwdata_i[atx_pkg::CFG_MRST_BIT];
            end
        end
    end

    // Chip select stays low between bytes until software marks a byte as last.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state     <= H_IDLE;
            timer     <= 8'h00;
            tx_byte   <= 8'h00;
            rx_byte   <= 8'h00;
            bits      <= 3'h0;
            last      <= 1'b0;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
        end else begin
            timer <= (state == H_IDLE || tmo) ? 8'h00 : timer + 8'h01;
            case (state)
                H_IDLE: begin
                    if (start) begin
                        tx_byte   <= pwdata_i[7:0];
                        last      <= pwdata_i[atx_pkg::CMD_LAST_BIT];
                        bits      <= 3'h0;
                        link.cs_n <= 1'b0;
                        link.mosi <= pwdata_i[7];
                        state     <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tmo) begin
                        link.sclk <= 1'b1;
                        rx_byte   <= {rx_byte[6:0], link.miso_line};
                        state     <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tmo) begin
                        link.sclk <= 1'b0;
                        bits      <= bits + 3'h1;
                        tx_byte   <= {tx_byte[6:0], 1'b0};
                        link.mosi <= tx_byte[6];
                        if (bits == 3'h7) begin
                            state <= last ? H_END : H_IDLE;
                        end else begin
                            state <= H_LOW;
                        end
                    end
                end
                H_END: begin
                    if (tmo) begin
                        link.cs_n <= 1'b1;
                        state     <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end
endmodule // atx_host

// [tb/atx_link_monitor.sv]
`timescale 1ns/100ps
module atx_link_monitor (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic master_reset,
    input wire logic line_out_a_o,
    input wire logic line_out_b_o,
    input wire logic tx_flag_out_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_cs_rise; $rose(cs_n); endsequence
    sequence s_oe_gone; ##[0:2] !miso_oe; endsequence
    property p_sclk_idle; cs_n |-> !sclk; endproperty
    property p_mosi_hold; sclk && $past(sclk) |-> $stable(mosi); endproperty
    property p_oe_off; s_cs_rise |-> s_oe_gone; endproperty
    property p_oe_idle; cs_n && $past(cs_n, 3) |-> !miso_oe; endproperty
    property p_miso_edge; miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk; endproperty
    property p_no_both; !(line_out_a_o && line_out_b_o); endproperty
    property p_rst_null;
        master_reset |=> !line_out_a_o && !line_out_b_o && !tx_flag_out_o;
    endproperty
    property p_cmd_quiet; $fell(cs_n) |-> !miso_oe[*8]; endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("Serial clock high while deselected");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("Data in moved while serial clock high");
    a_oe_off: assert property (p_oe_off)
        else $error("Data out still driven after deselect");
    a_oe_idle: assert property (p_oe_idle)
        else $error("Data out driven while deselected");
    a_miso_edge: assert property (p_miso_edge)
        else $error("Data out changed while serial clock high");
    a_no_both: assert property (p_no_both)
        else $error("Both line outputs high");
    a_rst_null: assert property (p_rst_null)
        else $error("Outputs active during master reset");
    a_cmd_quiet: assert property (p_cmd_quiet)
        else $error("Data out driven during command byte");
endmodule // atx_link_monitor

// [tb/tb_arinc429_tx_spi_slave.sv]
`timescale 1ns/100ps
module tb_arinc429_tx_spi_slave;
    logic        clk_sys_i = 1'h0;
    logic        sys_rst_i = 1'h1;
    logic [11:0] paddr     = 12'h000;
    logic        psel      = 1'h0;
    logic        pen       = 1'h0;
    logic        pwr       = 1'h0;
    logic [31:0] pwd       = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        line_a;
    logic        line_b;
    logic        pa;
    logic        pb;
    logic        tf;
    logic        d1;
    logic        d0;
    logic        ss;
    logic        l1;
    logic        l0;
    logic        rf;
    logic [15:0] cr        = atx_pkg::CTRL_RST;
    logic        par       = 1'h1;
    logic        ev        = 1'h0;
    logic        bits[$];
    logic [31:0] q[$];
    int          seed      = 93729;
    int          bad_count = 0;
    int          cmp_count = 0;

    atx_link_if link ();
    atx_host #(.SCK_HALF(4)) atx_host_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .paddr_i(paddr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link));
    atx_dev atx_dev_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link),
        .line_out_a_o(line_a), .line_out_b_o(line_b), .drive_one_out_o(d1),
        .drive_zero_out_o(d0), .slow_slope_o(ss), .loop_one_o(l1), .loop_zero_o(l0),
        .rx_flag_out_o(rf), .tx_flag_out_o(tf));
    atx_link_monitor atx_link_monitor_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
        .miso_oe(link.miso_oe), .master_reset(link.master_reset),
        .line_out_a_o(line_a), .line_out_b_o(line_b), .tx_flag_out_o(tf));

    initial forever #20 clk_sys_i = ~clk_sys_i;

    // Each bit has a Null half, so every bit shows as one rising edge on one output.
    always @(posedge clk_sys_i) begin
        pa <= line_a;
        pb <= line_b;
        if (line_a && !pa) bits.push_back(1'h1);
        if (line_b && !pb) bits.push_back(1'h0);
        if ({d1, d0, rf} !== {line_a, line_b, 1'h0}) begin
            bad_count++;
            $display("Error %0t: driver outputs disagree", $time);
        end
        if ({l1, l0} !== ({line_a, line_b} & ~{2{cr[atx_pkg::CR_LOOP_DIS]}})) begin
            bad_count++;
            $display("Error %0t: loopback outputs disagree", $time);
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        $display("Error %0t: wait ran out", $time);
        conclude();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        paddr <= ad;
        pwr   <= w;
        pwd   <= d;
        psel  <= 1'h1;
        @(posedge clk_sys_i);
        pen   <= 1'h1;
        do @(posedge clk_sys_i); while (pready !== 1'h1 && ++n < 20);
        if (n >= 20) hang();
        rd   = prdata;
        err  = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask

    task automatic spi(input logic [7:0] b, input logic s, input logic l);
        int n;
        n = 0;
        if (s) chk({31'h0, link.cs_n}, 32'h1);
        apb(12'h000, 1'h1, {22'h0, l, 1'h1, b});
        do apb(12'h004, 1'h0, 32'h0); while (rd[0] !== 1'h0 && ++n < 50);
        if (n >= 50) hang();
    endtask

    task automatic ctrl(input logic [15:0] c);
        spi(atx_pkg::OP_WR_CTRL, 1'h1, 1'h0);
        spi(c[15:8], 1'h0, 1'h0);
        spi(c[7:0], 1'h0, 1'h1);
        cr <= c;
        chk({31'h0, ss}, {31'h0, c[atx_pkg::CR_LOW_SPEED]});
    endtask

    task automatic stat(input logic [7:0] e);
        spi(atx_pkg::OP_RD_STAT, 1'h1, 1'h0);
        spi(8'h00, 1'h0, 1'h1);
        chk({24'h0, rd[15:8] & 8'h38}, {24'h0, e});
    endtask

    task automatic load(input int k);
        logic [31:0] w;
        spi(atx_pkg::OP_WR_TXF, 1'h1, 1'h0);
        for (int i = 0; i < k; i++) begin
            w = $random(seed);
            if (q.size() < 32) q.push_back(w);
            for (int j = 3; j >= 0; j--) spi(w[8*j+:8], 1'h0, 1'(i == k - 1 && j == 0));
        end
    endtask

    task automatic word();
        logic [31:0] w;
        logic [31:0] g;
        int n;
        w = q.pop_front();
        n = 0;
        if (par) w[31] = ^w[30:0] ^ !ev;
        while (bits.size() < 32 && n++ < 20000) @(posedge clk_sys_i);
        if (bits.size() < 32) hang();
        for (int i = 0; i < 32; i++) g[i] = bits.pop_front();
        chk(g, w);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'h0;
        apb(12'h00C, 1'h0, 32'h0);
        chk({31'h0, err}, 32'h1);
        stat(8'h08);
        ctrl(16'h0008);
        load(2);
        stat(8'h00);
        spi(atx_pkg::OP_SEND, 1'h1, 1'h1);
        word();
        word();
        // Covers the last bit plus the 40-tick gap before the shifter goes idle.
        repeat (1500) @(posedge clk_sys_i);
        stat(8'h08);
        ctrl(16'h2208);
        ev = 1'h1;
        load(1);
        word();
        // Words loaded before the gap ends would join this send.
        repeat (1500) @(posedge clk_sys_i);
        ctrl(16'h0420);
        par = 1'h0;
        load(33);
        stat(8'h30);
        spi(atx_pkg::OP_CLR_TXF, 1'h1, 1'h1);
        q.delete();
        stat(8'h08);
        load(16);
        stat(8'h10);
        chk({31'h0, tf}, 32'h1);
        apb(12'h008, 1'h1, 32'h1);
        apb(12'h008, 1'h1, 32'h0);
        q.delete();
        stat(8'h08);
        chk({31'h0, tf}, 32'h0);
        spi(atx_pkg::OP_RD_CTRL, 1'h1, 1'h0);
        spi(8'h00, 1'h0, 1'h0);
        chk({24'h0, rd[15:8]}, 32'h00000004);
        spi(8'h00, 1'h0, 1'h1);
        chk({24'h0, rd[15:8]}, 32'h00000020);
        ctrl(16'h0020);
        load(1);
        spi(atx_pkg::OP_SEND, 1'h1, 1'h1);
        word();
        conclude();
    end
endmodule // tb_arinc429_tx_spi_slave
